//--- tape_record_formatter_pkg.sv
/*
 Constants, field layout, register map and state types of the tape record formatter.
 Assumes a 20 MHz system clock and a tape unit that takes one frame per frame period.
*/
package tape_record_formatter_pkg;
	localparam int CLK_PERIOD_NS   = 50;
	localparam int FRAME_PERIOD_NS = 12000;
	localparam int FRAME_CYCLES    = FRAME_PERIOD_NS / CLK_PERIOD_NS;
	localparam int WORD_W          = 28;
	localparam int SUM_W           = 30;
	localparam int GROUP_W         = 6;
	localparam int FRAME_W         = 7;
	localparam int COORD_W         = 14;
	localparam int STAR_ID_W       = 12;
	localparam int LOC_W           = 6;
	localparam int BANK_WORDS      = 64;
	localparam int INGRESS_LSB     = 0;
	localparam int WIDTH_LSB       = 14;
	localparam int WIDTH_W         = 10;
	localparam int FILL_LSB        = 24;
	localparam logic [2:0] NORMAL_TOP_GROUP = 3'h3;
	localparam logic [2:0] TEST_TOP_GROUP   = 3'h4;
	localparam logic [1:0] BLANK_FRAMES     = 2'h3;
	localparam logic [5:0] FILE_MARK_PATTERN = 6'h0F;
	localparam logic [7:0] REEL_ONE         = 8'h01;
	localparam logic [5:0] LAST_LOC         = 6'h3F;
	localparam logic [3:0] ADDR_CONTROL     = 4'h0;
	localparam logic [3:0] ADDR_IDENT       = 4'h4;
	localparam logic [3:0] ADDR_STATUS      = 4'h8;
	localparam logic [3:0] ADDR_FRAMES      = 4'hC;
	localparam int CTRL_TEST_BIT  = 0;
	localparam int CTRL_IDENT_BIT = 1;
	localparam int CTRL_EXT_BIT   = 2;
	localparam logic        TEST_MODE_RESET = 1'b0;
	localparam logic [23:0] IDENT_RESET     = 24'h00_0000;
	typedef enum logic [3:0] {
		T_IDLE, T_CLEAR, T_WAIT, T_FRAMES, T_BLANK, T_CHECK, T_GAP, T_MARK_GAP, T_MARK, T_MARK_CHECK
	} tape_state_t;
	typedef enum logic [1:0] {SRC_EXT, SRC_BANK, SRC_IDENT} word_source_t;
endpackage

//--- frame_builder.sv
/*
 Frame builder: adds the odd parity track to a 6-bit group and keeps the per-track
 running parity from which the record check character is formed.
 Assumes the caller strobes accumulate once per emitted data or mark frame and clears after the check.
*/
`timescale 1ns/100ps
module frame_builder (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       accumulate,
	input  wire logic       clearAcc,
	input  wire logic [5:0] groupData,
	output logic      [6:0] dataFrame,
	output logic      [6:0] checkFrame
);
	logic [6:0] trackParity;

	assign dataFrame  = {~^groupData, groupData};
	assign checkFrame = trackParity;

	genvar t;
	generate
		for (t = 0; t < 7; t++)
		begin : g_track
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
					trackParity[t] <= 1'b0;
				else if (clearAcc)
					trackParity[t] <= 1'b0;
				else if (accumulate)
					trackParity[t] <= trackParity[t] ^ dataFrame[t];
			end
		end
	endgenerate
endmodule

//--- tape_record_formatter.sv
/*
 Tape record formatter: memory output register, star-width adder, frame disassembly,
 record and file mark framing, plate/reel identifier and reference star entry banks.
 Assumes an Avalon-MM master with waitrequest, a memory that answers a cycle request
 with memReadValid, and a tape unit that accepts a frame per frame period while ready.
*/
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
module tape_record_formatter (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             memCycleRequest,
	input  wire logic        memReadValid,
	input  wire logic [27:0] memReadData,
	input  wire logic        memWordIsStar,
	input  wire logic        memLastWord,
	input  wire logic [3:0]  widthHoldingRegister,
	input  wire logic [5:0]  firstIngressHoldingRegister,
	input  wire logic [5:0]  secondIngressHoldingRegister,
	input  wire logic [13:0] xPositionCounter,
	input  wire logic [13:0] yPositionCounter,
	input  wire logic [11:0] starTableNumber,
	input  wire logic        enterStar,
	input  wire logic        entryTerminateButton,
	input  wire logic        tapeReady,
	output logic      [6:0]  tapeFrame,
	output logic             tapeStrobe,
	output logic             recordGap,
	output logic             fileMarkGap
);
	tape_record_formatter_pkg::tape_state_t  state;
	tape_record_formatter_pkg::word_source_t source;

	logic [27:0] memoryOutputRegister;
	logic [23:0] auxiliaryAddendRegister;
	logic        starCarry;
	logic [9:0]  widthSum;
	logic [13:0] ingressSum;
	logic [29:0] adderOut;
	logic [7:0]  tickCount;
	logic        frameTick;
	logic        emit;
	logic [2:0]  groupIndex;
	logic [1:0]  blankCount;
	logic        lastWord;
	logic [5:0]  groupData;
	logic [6:0]  dataFrame;
	logic [6:0]  checkFrame;
	logic        avsAck;
	logic        testMode;
	logic [15:0] plateNumberField;
	logic [7:0]  reelNumberField;
	logic        identPending;
	logic        extPending;
	logic        markPending;
	logic [15:0] frameCount;
	logic [27:0] bankMem [0:2*tape_record_formatter_pkg::BANK_WORDS-1];
	logic [27:0] bankReadData;
	logic        dumpBank;
	logic [5:0]  readLoc;
	logic [1:0]  bankFull;
	logic        bankDone;
	logic [6:0]  writePtr;
	logic [1:0]  entryStep;
	logic        filling;
	logic        entryArmed;
	logic        enterPrev;
	logic        terminatePrev;
	logic        termFlag;
	logic        termBank;
	logic        entryWrite;
	logic [27:0] entryWord;
	logic [27:0] sourceWord;
	logic        sourceValid;
	logic        sourceStar;
	logic [27:0] loadWord;

	// Avalon-MM slave: every access waits exactly one cycle
	assign avs_waitrequest = (avs_read | avs_write) & ~avsAck;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			avsAck <= 1'b0;
		else
			avsAck <= (avs_read | avs_write) & ~avsAck;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !avsAck)
		begin
			case (avs_address)
				tape_record_formatter_pkg::ADDR_CONTROL: avs_readdata <= {31'h0000_0000, testMode};
				tape_record_formatter_pkg::ADDR_IDENT:   avs_readdata <= {8'h00, plateNumberField, reelNumberField};
				tape_record_formatter_pkg::ADDR_STATUS:
					avs_readdata <= {24'h00_0000, filling, entryArmed, bankFull, identPending | extPending,
						markPending, termFlag, state != tape_record_formatter_pkg::T_IDLE};
				tape_record_formatter_pkg::ADDR_FRAMES:  avs_readdata <= {16'h0000, frameCount};
				default:                                 avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			testMode         <= tape_record_formatter_pkg::TEST_MODE_RESET;
			plateNumberField <= tape_record_formatter_pkg::IDENT_RESET[23:8];
			reelNumberField  <= tape_record_formatter_pkg::IDENT_RESET[7:0];
		end
		else if (avs_write && avsAck)
		begin
			if (avs_address == tape_record_formatter_pkg::ADDR_CONTROL)
				testMode <= avs_writedata[tape_record_formatter_pkg::CTRL_TEST_BIT];
			if (avs_address == tape_record_formatter_pkg::ADDR_IDENT)
			begin
				plateNumberField <= avs_writedata[23:8];
				reelNumberField  <= avs_writedata[7:0];
			end
		end
	end

	// Request flags: a new request in the cycle the engine takes the old one is kept
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			identPending <= 1'b0;
			extPending   <= 1'b0;
		end
		else
		begin
			identPending <= (identPending & ~(state == tape_record_formatter_pkg::T_CLEAR &&
				source == tape_record_formatter_pkg::SRC_IDENT)) | (avs_write && avsAck &&
				avs_address == tape_record_formatter_pkg::ADDR_CONTROL &&
				avs_writedata[tape_record_formatter_pkg::CTRL_IDENT_BIT]);
			extPending <= (extPending & ~(state == tape_record_formatter_pkg::T_IDLE && bankFull == 2'h0 &&
				!identPending)) | (avs_write && avsAck && avs_address == tape_record_formatter_pkg::ADDR_CONTROL
				&& avs_writedata[tape_record_formatter_pkg::CTRL_EXT_BIT]);
		end
	end

	// Frame rate divider
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			tickCount <= 8'h00;
		else if (tickCount == 8'(tape_record_formatter_pkg::FRAME_CYCLES - 1))
			tickCount <= 8'h00;
		else
			tickCount <= tickCount + 8'h01;
	end
	assign frameTick = tickCount == 8'(tape_record_formatter_pkg::FRAME_CYCLES - 1);
	assign emit      = frameTick & tapeReady;

	// Adder: upper field adds the inverted subtrahend plus a carry, so no subtractor exists
	assign widthSum   = memoryOutputRegister[23:14] + auxiliaryAddendRegister[23:14] + {9'h000, starCarry};
	assign ingressSum = memoryOutputRegister[13:0] + auxiliaryAddendRegister[13:0];
	assign adderOut   = {2'b00, memoryOutputRegister[27:24], widthSum, ingressSum};

	always_comb
	begin
		case (source)
			tape_record_formatter_pkg::SRC_EXT:
			begin
				sourceWord  = memReadData;
				sourceValid = memReadValid;
				sourceStar  = memWordIsStar;
			end
			tape_record_formatter_pkg::SRC_BANK:
			begin
				sourceWord  = bankReadData;
				sourceValid = 1'b1;
				sourceStar  = 1'b0;
			end
			default:
			begin
				sourceWord  = {4'h0, plateNumberField, reelNumberField};
				sourceValid = 1'b1;
				sourceStar  = 1'b0;
			end
		endcase
		loadWord = sourceWord;
		if (sourceStar)
			loadWord[23:14] = {widthHoldingRegister, secondIngressHoldingRegister};
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			memoryOutputRegister    <= 28'h000_0000;
			auxiliaryAddendRegister <= 24'h00_0000;
			starCarry               <= 1'b0;
		end
		else if (state == tape_record_formatter_pkg::T_CLEAR)
		begin
			memoryOutputRegister    <= 28'h000_0000;
			auxiliaryAddendRegister <= 24'h00_0000;
			starCarry               <= 1'b0;
		end
		else if (state == tape_record_formatter_pkg::T_WAIT && sourceValid)
		begin
			memoryOutputRegister <= memoryOutputRegister | loadWord;
			if (sourceStar)
			begin
				auxiliaryAddendRegister <= {~{4'h0, firstIngressHoldingRegister}, 14'h0000};
				starCarry               <= 1'b1;
			end
			else
			begin
				auxiliaryAddendRegister <= 24'h00_0000;
				starCarry               <= 1'b0;
			end
		end
	end

	always_comb
	begin
		if (state == tape_record_formatter_pkg::T_MARK)
			groupData = tape_record_formatter_pkg::FILE_MARK_PATTERN;
		else
			groupData = adderOut[6 * groupIndex +: 6];
	end

	frame_builder u_frame_builder (
		.clk        (clk),
		.rstn       (rstn),
		.accumulate (emit && (state == tape_record_formatter_pkg::T_FRAMES || state == tape_record_formatter_pkg::T_MARK)),
		.clearAcc   (emit && (state == tape_record_formatter_pkg::T_CHECK ||
			state == tape_record_formatter_pkg::T_MARK_CHECK)),
		.groupData  (groupData),
		.dataFrame  (dataFrame),
		.checkFrame (checkFrame)
	);

	assign bankDone = emit && state == tape_record_formatter_pkg::T_GAP && source == tape_record_formatter_pkg::SRC_BANK;

	// Tape sequencing
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state           <= tape_record_formatter_pkg::T_IDLE;
			source          <= tape_record_formatter_pkg::SRC_EXT;
			dumpBank        <= 1'b0;
			readLoc         <= 6'h00;
			groupIndex      <= 3'h0;
			blankCount      <= 2'h0;
			lastWord        <= 1'b0;
			markPending     <= 1'b0;
			memCycleRequest <= 1'b0;
		end
		else
		begin
			memCycleRequest <= 1'b0;
			case (state)
				tape_record_formatter_pkg::T_IDLE:
				begin
					readLoc <= 6'h00;
					if (bankFull != 2'h0)
					begin
						source   <= tape_record_formatter_pkg::SRC_BANK;
						dumpBank <= ~bankFull[0];
						state    <= tape_record_formatter_pkg::T_CLEAR;
					end
					else if (identPending)
					begin
						source <= tape_record_formatter_pkg::SRC_IDENT;
						state  <= tape_record_formatter_pkg::T_CLEAR;
					end
					else if (extPending)
					begin
						source          <= tape_record_formatter_pkg::SRC_EXT;
						memCycleRequest <= 1'b1;
						state           <= tape_record_formatter_pkg::T_CLEAR;
					end
					else if (markPending)
						state <= tape_record_formatter_pkg::T_MARK_GAP;
				end
				tape_record_formatter_pkg::T_CLEAR:
					state <= tape_record_formatter_pkg::T_WAIT;
				tape_record_formatter_pkg::T_WAIT:
					if (sourceValid)
					begin
						case (source)
							tape_record_formatter_pkg::SRC_EXT:  lastWord <= memLastWord;
							tape_record_formatter_pkg::SRC_BANK: lastWord <= readLoc == tape_record_formatter_pkg::LAST_LOC;
							default:                             lastWord <= 1'b1;
						endcase
						groupIndex <= testMode ? tape_record_formatter_pkg::TEST_TOP_GROUP :
							tape_record_formatter_pkg::NORMAL_TOP_GROUP;
						state <= tape_record_formatter_pkg::T_FRAMES;
					end
				tape_record_formatter_pkg::T_FRAMES:
					if (emit)
					begin
						if (groupIndex != 3'h0)
							groupIndex <= groupIndex - 3'h1;
						else if (lastWord)
						begin
							blankCount <= tape_record_formatter_pkg::BLANK_FRAMES - 2'h1;
							state      <= tape_record_formatter_pkg::T_BLANK;
						end
						else
						begin
							readLoc         <= readLoc + 6'h01;
							memCycleRequest <= source == tape_record_formatter_pkg::SRC_EXT;
							state           <= tape_record_formatter_pkg::T_CLEAR;
						end
					end
				tape_record_formatter_pkg::T_BLANK:
					if (emit)
					begin
						if (blankCount == 2'h0)
							state <= tape_record_formatter_pkg::T_CHECK;
						else
							blankCount <= blankCount - 2'h1;
					end
				tape_record_formatter_pkg::T_CHECK:
					if (emit)
						state <= tape_record_formatter_pkg::T_GAP;
				tape_record_formatter_pkg::T_GAP:
					if (emit)
					begin
						if (source == tape_record_formatter_pkg::SRC_IDENT ||
							(source == tape_record_formatter_pkg::SRC_BANK && termFlag && termBank == dumpBank))
							markPending <= 1'b1;
						state <= tape_record_formatter_pkg::T_IDLE;
					end
				tape_record_formatter_pkg::T_MARK_GAP:
					if (emit)
						state <= tape_record_formatter_pkg::T_MARK;
				tape_record_formatter_pkg::T_MARK:
					if (emit)
						state <= tape_record_formatter_pkg::T_MARK_CHECK;
				tape_record_formatter_pkg::T_MARK_CHECK:
					if (emit)
					begin
						markPending <= 1'b0;
						state       <= tape_record_formatter_pkg::T_IDLE;
					end
				default:
					state <= tape_record_formatter_pkg::T_IDLE;
			endcase
		end
	end

	// Tape outputs; blank frames carry no parity so the controller can spot them
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tapeFrame   <= 7'h00;
			tapeStrobe  <= 1'b0;
			recordGap   <= 1'b0;
			fileMarkGap <= 1'b0;
			frameCount  <= 16'h0000;
		end
		else
		begin
			tapeStrobe  <= 1'b0;
			recordGap   <= emit && state == tape_record_formatter_pkg::T_GAP;
			fileMarkGap <= emit && state == tape_record_formatter_pkg::T_MARK_GAP;
			if (emit && (state == tape_record_formatter_pkg::T_FRAMES || state == tape_record_formatter_pkg::T_MARK))
			begin
				tapeFrame  <= dataFrame;
				tapeStrobe <= 1'b1;
				frameCount <= frameCount + 16'h0001;
			end
			else if (emit && state == tape_record_formatter_pkg::T_BLANK)
			begin
				tapeFrame  <= 7'h00;
				tapeStrobe <= 1'b1;
			end
			else if (emit && (state == tape_record_formatter_pkg::T_CHECK ||
				state == tape_record_formatter_pkg::T_MARK_CHECK))
			begin
				tapeFrame  <= checkFrame;
				tapeStrobe <= 1'b1;
			end
		end
	end

	// Reference star entry into the two banks
	always_comb
	begin
		case (entryStep)
			2'h1:    entryWord = {14'h0000, xPositionCounter};
			2'h2:    entryWord = {14'h0000, yPositionCounter};
			2'h3:    entryWord = {16'h0000, starTableNumber};
			default: entryWord = 28'h000_0000;
		endcase
	end
	assign entryWrite = entryStep != 2'h0 || filling;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			enterPrev     <= 1'b0;
			terminatePrev <= 1'b0;
			entryStep     <= 2'h0;
			filling       <= 1'b0;
			writePtr      <= 7'h00;
			entryArmed    <= 1'b0;
			termFlag      <= 1'b0;
			termBank      <= 1'b0;
		end
		else
		begin
			enterPrev     <= enterStar;
			terminatePrev <= entryTerminateButton;
			if (bankDone && termFlag && termBank == dumpBank)
				termFlag <= 1'b0;
			if (emit && state == tape_record_formatter_pkg::T_GAP && source == tape_record_formatter_pkg::SRC_IDENT)
			begin
				entryArmed <= reelNumberField == tape_record_formatter_pkg::REEL_ONE;
				writePtr   <= 7'h00;
			end
			if (entryArmed && !filling && entryStep == 2'h0 && enterStar && !enterPrev)
				entryStep <= 2'h1;
			else if (entryArmed && !filling && entryStep == 2'h0 && entryTerminateButton && !terminatePrev)
				filling <= 1'b1;
			else if (entryStep != 2'h0)
				entryStep <= entryStep + 2'h1;
			if (entryWrite)
			begin
				writePtr <= writePtr + 7'h01;
				if (filling && writePtr[5:0] == tape_record_formatter_pkg::LAST_LOC && entryStep == 2'h0)
				begin
					filling    <= 1'b0;
					entryArmed <= 1'b0;
					termFlag   <= 1'b1;
					termBank   <= writePtr[6];
				end
			end
		end
	end

	// Bank memory: a bank overwritten while still waiting for tape is lost
	always_ff @(posedge clk)
	begin
		if (entryWrite)
			bankMem[writePtr] <= entryWord;
		bankReadData <= bankMem[{dumpBank, readLoc}];
	end

	genvar b;
	generate
		for (b = 0; b < 2; b++)
		begin : g_bank
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
					bankFull[b] <= 1'b0;
				else
					bankFull[b] <= (bankFull[b] & ~(bankDone && dumpBank == b)) |
						(entryWrite && writePtr[5:0] == tape_record_formatter_pkg::LAST_LOC && writePtr[6] == b);
			end
		end
	endgenerate
endmodule

//--- tape_record_formatter_checker.sv
/*
 Port checker for the tape record formatter: bus wait cycle, frame slots, record and file mark framing.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module tape_record_formatter_checker (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic       memCycleRequest,
	input wire logic       tapeReady,
	input wire logic [6:0] tapeFrame,
	input wire logic       tapeStrobe,
	input wire logic       recordGap,
	input wire logic       fileMarkGap
);
	logic [1:0] blankRun;
	logic       afterCheck;
	logic       markPend;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Saturates so a long blank run still reads as three or more
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			blankRun <= 2'h0;
		else if (tapeStrobe)
			blankRun <= (tapeFrame != 7'h00) ? 2'h0 : ((blankRun == 2'h3) ? 2'h3 : blankRun + 2'h1);
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			afterCheck <= 1'b0;
		else if (tapeStrobe)
			// The frame after three blanks is the check char, which may itself be all zero
			afterCheck <= (blankRun == 2'h3);
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			markPend <= 1'b0;
		else if (fileMarkGap)
			markPend <= 1'b1;
		else if (tapeStrobe)
			markPend <= 1'b0;
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_go;
		!avs_waitrequest;
	endsequence
	sequence s_quiet;
		!tapeStrobe [*8];
	endsequence
	one_wait_a: assert property (s_req |=> s_go) else $error("bus wait longer than one cycle");
	first_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest) else $error("read answered at once");
	strobe_space_a: assert property (tapeStrobe |=> s_quiet) else $error("frames too close");
	slot_ready_a: assert property (tapeStrobe |-> $past(tapeReady)) else $error("frame without ready");
	frame_odd_a: assert property (tapeStrobe && tapeFrame != 7'h00 && blankRun == 2'h0 |-> ^tapeFrame)
		else $error("frame parity even");
	blank_count_a: assert property (tapeStrobe && tapeFrame != 7'h00 && blankRun != 2'h0 |-> blankRun == 2'h3)
		else $error("check char not after three blanks");
	gap_follows_a: assert property (recordGap |-> afterCheck && !tapeStrobe) else $error("gap not after check");
	mark_frame_a: assert property (tapeStrobe && markPend |-> tapeFrame == 7'h4F) else $error("bad mark frame");
	frame_stands_a: assert property (!tapeStrobe |-> $stable(tapeFrame)) else $error("frame moved between strobes");
	mem_pulse_a: assert property (memCycleRequest |=> !memCycleRequest) else $error("cycle request too long");
endmodule

//--- tape_unit_model.sv
/*
 Tape unit model: takes frames, stalls at random, checks frame parity and the parity of the six data tracks per record.
 Assumes the bench seeds the random generator and reads got and pErr by hierarchy.
*/
`timescale 1ns/100ps
module tape_unit_model (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       tapeStrobe,
	input wire logic       recordGap,
	input wire logic [6:0] tapeFrame,
	output logic           tapeReady
);
	logic [6:0] got[$];
	logic [5:0] trk;
	int         blanks;
	int         pErr;
	always @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			tapeReady <= 1'b0;
			trk = 6'h00;
			blanks = 0;
			pErr = 0;
		end
		else
		begin
			// Rare stalls keep the long bank record inside the run budget
			tapeReady <= ($urandom % 16) != 0;
			if (tapeStrobe)
			begin
				got.push_back(tapeFrame);
				trk ^= tapeFrame[5:0];
				if (tapeFrame == 7'h00)
					blanks++;
				else
				begin
					if (blanks == 0 && !(^tapeFrame))
						pErr++;
					blanks = 0;
				end
			end
			if (recordGap)
			begin
				if (trk != 6'h00)
					pErr++;
				trk = 6'h00;
			end
		end
endmodule

//--- tb.sv
/*
 Self-checking bench for the tape record formatter: bus tasks, memory answerer, frame model.
 Assumes the tape unit model and checker are compiled alongside.
*/
`timescale 1ns/100ps
module tb;
	logic        clk, rstn, avs_read, avs_write, avs_waitrequest, memCycleRequest, memReadValid;
	logic        memWordIsStar, memLastWord, enterStar, entryTerminateButton, tapeReady, tapeStrobe;
	logic        recordGap, fileMarkGap;
	logic [3:0]  avs_address, widthHoldingRegister;
	logic [5:0]  firstIngressHoldingRegister, secondIngressHoldingRegister;
	logic [6:0]  tapeFrame, acc;
	logic [11:0] starTableNumber;
	logic [13:0] xPositionCounter, yPositionCounter;
	logic [27:0] memReadData;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [44:0] m;
	logic [44:0] mq[$];
	logic [6:0]  exp[$];
	int          err_total, num_checks, cyc, nData;
	tape_record_formatter dut_u (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .memCycleRequest(memCycleRequest), .memReadValid(memReadValid),
		.memReadData(memReadData), .memWordIsStar(memWordIsStar), .memLastWord(memLastWord),
		.widthHoldingRegister(widthHoldingRegister), .firstIngressHoldingRegister(firstIngressHoldingRegister),
		.secondIngressHoldingRegister(secondIngressHoldingRegister), .xPositionCounter(xPositionCounter),
		.yPositionCounter(yPositionCounter), .starTableNumber(starTableNumber), .enterStar(enterStar),
		.entryTerminateButton(entryTerminateButton), .tapeReady(tapeReady), .tapeFrame(tapeFrame),
		.tapeStrobe(tapeStrobe), .recordGap(recordGap), .fileMarkGap(fileMarkGap));
	tape_unit_model tp (.clk(clk), .rstn(rstn), .tapeStrobe(tapeStrobe), .recordGap(recordGap),
		.tapeFrame(tapeFrame), .tapeReady(tapeReady));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want)
		begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task close_out;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		// Request stands until the rising edge that samples waitrequest low; data taken there
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task put(input logic [29:0] v, input int n);
		logic [5:0] g;
		for (int k = n - 1; k >= 0; k--)
		begin
			g = v[6 * k +: 6];
			exp.push_back({~^g, g});
			nData++;
			acc ^= {~^g, g};
		end
	endtask
	task endrec;
		repeat (3) exp.push_back(7'h00);
		exp.push_back(acc);
		acc = 7'h00;
	endtask
	task word(input logic star, input int n);
		logic [27:0] w;
		logic [3:0]  hw;
		logic [5:0]  h1, h2;
		w = $urandom;
		hw = $urandom;
		h1 = $urandom;
		h2 = $urandom;
		mq.push_back({star, hw, h1, h2, w});
		if (star)
			w[23:14] = {hw, h2} - {4'h0, h1};
		put({2'b00, w}, n);
	endtask
	task drain;
		while (tp.got.size() < exp.size()) @(posedge clk);
		repeat (400) @(posedge clk);
	endtask
	// Data is inverted once valid drops so a stale word is never mistaken for a fresh one
	always @(negedge clk)
		if (memCycleRequest === 1'b1 && mq.size() > 0)
		begin
			m = mq.pop_front();
			repeat (2 + $urandom % 4) @(posedge clk);
			memReadValid <= 1'b1;
			{memWordIsStar, widthHoldingRegister, firstIngressHoldingRegister,
				secondIngressHoldingRegister, memReadData} <= m;
			memLastWord <= mq.size() == 0;
			repeat (2) @(posedge clk);
			memReadValid <= 1'b0;
			memReadData <= ~m[27:0];
		end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 99000)
		begin
			err_total++;
			close_out;
		end
	end
	initial
	begin
		void'($urandom(30));
		{rstn, avs_read, avs_write, memReadValid, memWordIsStar, memLastWord, enterStar} = 7'h00;
		{avs_address, widthHoldingRegister, firstIngressHoldingRegister, secondIngressHoldingRegister} = 20'h0;
		{starTableNumber, xPositionCounter, yPositionCounter, memReadData} = 68'h0;
		{entryTerminateButton, avs_writedata, acc} = 40'h0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		bus(0, tape_record_formatter_pkg::ADDR_CONTROL, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		bus(0, tape_record_formatter_pkg::ADDR_IDENT, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		bus(1, 4'h2, 32'hFFFF_FFFF, rd);
		bus(0, 4'h2, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		for (int i = 0; i < 4; i++)
			word(i[0], 4);
		endrec;
		bus(1, tape_record_formatter_pkg::ADDR_CONTROL, 32'h0000_0004, rd);
		drain;
		bus(1, tape_record_formatter_pkg::ADDR_CONTROL, 32'h0000_0001, rd);
		bus(0, tape_record_formatter_pkg::ADDR_CONTROL, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0001);
		word(0, 5);
		word(0, 5);
		endrec;
		bus(1, tape_record_formatter_pkg::ADDR_CONTROL, 32'h0000_0005, rd);
		drain;
		bus(1, tape_record_formatter_pkg::ADDR_CONTROL, 32'h0000_0000, rd);
		bus(1, tape_record_formatter_pkg::ADDR_IDENT, 32'h0012_3401, rd);
		put(30'h0012_3401, 4);
		endrec;
		repeat (2) exp.push_back(7'h4F);
		nData++;
		bus(1, tape_record_formatter_pkg::ADDR_CONTROL, 32'h0000_0002, rd);
		drain;
		bus(0, tape_record_formatter_pkg::ADDR_STATUS, 32'h0000_0000, rd);
		chk(32'(rd[6]), 32'h0000_0001);
		xPositionCounter <= $urandom;
		yPositionCounter <= $urandom;
		starTableNumber <= $urandom;
		repeat (4) @(posedge clk);
		enterStar <= 1'b1;
		repeat (10) @(posedge clk);
		enterStar <= 1'b0;
		repeat (10) @(posedge clk);
		entryTerminateButton <= 1'b1;
		repeat (10) @(posedge clk);
		entryTerminateButton <= 1'b0;
		put({16'h0000, xPositionCounter}, 4);
		put({16'h0000, yPositionCounter}, 4);
		put({18'h0_0000, starTableNumber}, 4);
		repeat (61) put(30'h0000_0000, 4);
		endrec;
		repeat (2) exp.push_back(7'h4F);
		nData++;
		drain;
		bus(0, tape_record_formatter_pkg::ADDR_STATUS, 32'h0000_0000, rd);
		chk(32'(rd[6]), 32'h0000_0000);
		bus(0, tape_record_formatter_pkg::ADDR_FRAMES, 32'h0000_0000, rd);
		chk(rd, 32'(nData));
		chk(32'(tp.got.size()), 32'(exp.size()));
		for (int i = 0; i < exp.size() && i < tp.got.size(); i++)
			chk(32'(tp.got[i]), 32'(exp[i]));
		chk(32'(tp.pErr), 32'h0000_0000);
		close_out;
	end
endmodule
bind tape_record_formatter tape_record_formatter_checker chk_u (.clk(clk), .rstn(rstn), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .memCycleRequest(memCycleRequest),
	.tapeReady(tapeReady), .tapeFrame(tapeFrame), .tapeStrobe(tapeStrobe), .recordGap(recordGap),
	.fileMarkGap(fileMarkGap));
